/* File: hw/tx_cell_available_flow_control.sv */
// cell-available flow control for the transmit utopia port
`timescale 1ns/1ps
// How it works
// RL1: octet mode: low when under four words room
// RL2: octet mode: high with room for four
// RL3: cell mode: high with room for a cell
// RL4: cell mode: low without room for a cell
// RL5: multi-phy: tri-state until cycle after address match (code drives two cycles after the match)
// RL6: multi-phy selected: cell-level behaviour
// RL7: drive only in atm uni mode
// RL8: partner writes word while enable low
// RL9: partner pulses start-of-cell on first word
// RL10: output updates on rising clock edge
module tx_cell_available_flow_control
  import clav_pkg::*;
(
  input  wire logic              mclk_i,
  input  wire logic              reset_i,
  input  wire mode_s             mode_i,
  input  wire logic [ADDR_W-1:0] tx_addr_i,
  input  wire logic              tx_write_enable_n_i,
  input  wire logic              tx_start_of_cell_in_i,
  input  wire logic [WORD_W-1:0] tx_data_i,
  input  wire logic              fifo_ready_i,
  input  wire logic              fifo_read_i,
  output logic                   tx_cell_available_out_o,
  output logic                   tx_cell_available_oe_o,
  output word_s                  fifo_word_o,
  output logic [FILL_W-1:0]      fill_o
);
  // ==========================================================================
  // state
  typedef struct packed {
    logic [FILL_W-1:0] fill;
    logic              selected;
    logic              clav;
    logic              oe;
    word_s             fifo_word;
  } state_s;

  state_s st;
  state_s next_st;
  word_s  in_word;
  word_s  buf_word;
  logic   buf_in_ready;

  function automatic logic [FILL_W-1:0] room(input logic [FILL_W-1:0] used,
                                             input logic              bus16);
    room = (bus16 ? FIFO_WORDS_16 : FIFO_WORDS_8) - used;
  endfunction

  // ==========================================================================
  // write capture
  always_comb begin
    in_word.valid = ~tx_write_enable_n_i & mode_i.atm_uni; // [RL8]
    in_word.soc   = tx_start_of_cell_in_i;                   // [RL9]
    in_word.data  = tx_data_i;
  end

  // holds up to two words while the fifo stalls; a word arriving with both slots full is dropped
  word_skid_buffer u_buf (
    .mclk_i      (mclk_i),
    .reset_i     (reset_i),
    .in_i        (in_word),
    .in_ready_o  (buf_in_ready),
    .out_o       (buf_word),
    .out_ready_i (fifo_ready_i)
  );

  // ==========================================================================
  // next state
  logic              wr_acc;
  logic              push;
  logic [FILL_W-1:0] free;
  logic [FILL_W-1:0] cell_w;
  logic              level;

  always_comb begin
    next_st   = st;
    wr_acc    = in_word.valid & buf_in_ready;
    push      = buf_word.valid & fifo_ready_i;
    // words in the skid buffer count as used so clav never overpromises
    next_st.fill = st.fill + {{(FILL_W-1){1'b0}}, wr_acc}
                 - {{(FILL_W-1){1'b0}}, fifo_read_i && st.fill != FILL_RESET};
    next_st.fifo_word       = buf_word;
    next_st.fifo_word.valid = push;
    free   = room(next_st.fill, mode_i.bus16);
    cell_w = mode_i.bus16 ? CELL_WORDS_16 : CELL_WORDS_8;
    if (mode_i.cell_level || mode_i.multi_phy) begin
      level = (free >= cell_w);             // [RL3] [RL4] [RL6]
    end else begin
      level = (free >= OCTET_ROOM_MIN);     // [RL1] [RL2]
    end
    next_st.clav = level;                   // [RL10]
    next_st.selected = mode_i.multi_phy ? (tx_addr_i == mode_i.port_addr) : 1'b1;
    // oe follows the registered match, two cycles after the address
    next_st.oe = mode_i.atm_uni & (~mode_i.multi_phy | st.selected); // [RL5] [RL7]
  end

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      st <= '0;
    end else begin
      st <= next_st;                        // [RL10]
    end
  end

  assign tx_cell_available_out_o = st.clav;
  assign tx_cell_available_oe_o  = st.oe;
  assign fifo_word_o             = st.fifo_word;
  assign fill_o                  = st.fill;

  // ==========================================================================
  // checks
  sequence addr_hit_s;
    mode_i.atm_uni && mode_i.multi_phy && tx_addr_i == mode_i.port_addr;
  endsequence

  property oe_after_match_p;
    @(posedge mclk_i) disable iff (reset_i)
      addr_hit_s ##1 (mode_i.atm_uni && mode_i.multi_phy) |=> tx_cell_available_oe_o;
  endproperty

  multiphy_select_a: assert property (oe_after_match_p) // [RL5]
    else $error("clav not driven after address match");

  multiphy_hold_a: assert property (@(posedge mclk_i) disable iff (reset_i) // [RL5]
    (mode_i.multi_phy && !st.selected) |=> !tx_cell_available_oe_o)
    else $error("clav driven without selection");

  clear_channel_a: assert property (@(posedge mclk_i) disable iff (reset_i) // [RL7]
    !mode_i.atm_uni |=> !tx_cell_available_oe_o)
    else $error("clav driven in clear channel mode");

  octet_low_a: assert property (@(posedge mclk_i) disable iff (reset_i) // [RL1]
    (!mode_i.cell_level && !mode_i.multi_phy && free < OCTET_ROOM_MIN)
      |=> !tx_cell_available_out_o)
    else $error("octet clav high with little room");

  octet_high_a: assert property (@(posedge mclk_i) disable iff (reset_i) // [RL2]
    (!mode_i.cell_level && !mode_i.multi_phy && free >= OCTET_ROOM_MIN)
      |=> tx_cell_available_out_o)
    else $error("octet clav low with room");

  cell_high_a: assert property (@(posedge mclk_i) disable iff (reset_i) // [RL3]
    (mode_i.cell_level && free >= cell_w) |=> tx_cell_available_out_o)
    else $error("cell clav low with room for a cell");

  cell_low_a: assert property (@(posedge mclk_i) disable iff (reset_i) // [RL4]
    (mode_i.cell_level && free < cell_w) |=> !tx_cell_available_out_o)
    else $error("cell clav high without a cell of room");

  multiphy_cell_a: assert property (@(posedge mclk_i) disable iff (reset_i) // [RL6]
    (mode_i.multi_phy && free < cell_w) |=> !tx_cell_available_out_o)
    else $error("multi-phy clav ignores cell rule");

  fill_count_a: assert property (@(posedge mclk_i) disable iff (reset_i) // [RL10]
    (wr_acc && !fifo_read_i) |=> fill_o == $past(fill_o) + 10'h001)
    else $error("fill not updated by write");

  // a read with nothing written must lower a non-zero count by exactly one
  fill_drop_a: assert property (@(posedge mclk_i) disable iff (reset_i) // [RL10]
    (fifo_read_i && !wr_acc && fill_o != FILL_RESET)
      |=> fill_o == $past(fill_o) - 10'h001)
    else $error("fill not lowered by read");

  multiphy_high_a: assert property (@(posedge mclk_i) disable iff (reset_i) // [RL6]
    (mode_i.multi_phy && free >= cell_w) |=> tx_cell_available_out_o)
    else $error("multi-phy clav low with room for a cell");

  // ==========================================================================
  // deselect, push and reset steps
  sequence addr_miss_s;
    mode_i.multi_phy && tx_addr_i != mode_i.port_addr;
  endsequence

  sequence still_multi_s;
    mode_i.multi_phy;
  endsequence

  property oe_after_miss_p;
    @(posedge mclk_i) disable iff (reset_i)
      addr_miss_s ##1 still_multi_s |=> !tx_cell_available_oe_o;
  endproperty

  multiphy_release_a: assert property (oe_after_miss_p) // [RL5]
    else $error("clav still driven after address left");

  // a word handed to a ready fifo must show up on the next edge
  fifo_push_a: assert property (@(posedge mclk_i) disable iff (reset_i) // [RL10]
    (buf_word.valid && fifo_ready_i) |=> fifo_word_o.valid)
    else $error("buffered word not pushed");

  fifo_idle_a: assert property (@(posedge mclk_i) disable iff (reset_i) // [RL10]
    !(buf_word.valid && fifo_ready_i) |=> !fifo_word_o.valid)
    else $error("word pushed without a ready fifo");

  // reset must leave the pin released and the count empty
  reset_quiet_a: assert property (@(posedge mclk_i) // [RL7]
    reset_i |=> (!tx_cell_available_oe_o && !tx_cell_available_out_o
                 && fill_o == FILL_RESET))
    else $error("outputs not cleared by reset");
endmodule

/* File: hw/clav_pkg.sv */
// shared constants and carriers for the transmit cell-available flow control
package clav_pkg;
  // ==========================================================================
  // sizes
  localparam int unsigned WORD_W         = 16;
  localparam int unsigned FILL_W         = 10;   // bits in the count of words held by the transmit fifo
  localparam int unsigned ADDR_W         = 5;
  localparam int unsigned BUF_DEPTH      = 2;
  localparam logic [FILL_W-1:0] OCTET_ROOM_MIN = 10'h004;
  localparam logic [FILL_W-1:0] FIFO_WORDS_8   = 10'h1b0; // 16 cells of 27 words
  localparam logic [FILL_W-1:0] FIFO_WORDS_16  = 10'h1b0;
  localparam logic [FILL_W-1:0] CELL_WORDS_8   = 10'h035; // 53 bytes
  localparam logic [FILL_W-1:0] CELL_WORDS_16  = 10'h01b; // 27 words
  localparam logic [FILL_W-1:0] FILL_RESET     = 10'h000;

  // ==========================================================================
  // carriers
  typedef struct packed {
    logic              valid;
    logic              soc;
    logic [WORD_W-1:0] data;
  } word_s;

  typedef struct packed {
    logic              atm_uni;     // low = clear-channel framer
    logic              cell_level;  // low = octet level
    logic              multi_phy;
    logic              bus16;
    logic [ADDR_W-1:0] port_addr;
  } mode_s;
endpackage

/* File: hw/word_skid_buffer.sv */
// two-entry buffer with valid and ready on both sides
`timescale 1ns/1ps
module word_skid_buffer
  import clav_pkg::*;
(
  input  wire logic  mclk_i,
  input  wire logic  reset_i,
  input  wire word_s in_i,
  output logic       in_ready_o,
  output word_s      out_o,
  input  wire logic  out_ready_i
);
  typedef struct packed {
    word_s [BUF_DEPTH-1:0] slot;
    logic                  rd;
    logic                  wr;
    logic [1:0]            count;
  } state_s;

  state_s st;
  state_s next_st;

  always_comb begin
    next_st = st;
    if (out_ready_i && st.count != 2'h0) begin
      next_st.rd    = ~st.rd;
      next_st.count = next_st.count - 2'h1;
    end
    if (in_i.valid && st.count != 2'h2) begin
      next_st.slot[st.wr] = in_i;
      next_st.wr          = ~st.wr;
      next_st.count       = next_st.count + 2'h1;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign in_ready_o = (st.count != 2'h2);
  always_comb begin
    out_o       = st.slot[st.rd];
    out_o.valid = (st.count != 2'h0);
  end
endmodule

/* File: bench/atm_partner.sv */
// atm layer processor model writing words into the transmit port
`timescale 1ns/1ps
module atm_partner
  import clav_pkg::*;
(
  input  wire logic         mclk_i,
  input  wire logic         clav_i,
  input  wire logic [31:0]  words_i,
  input  wire logic         go_i,
  output logic              done_o,
  output logic              wr_n_o,
  output logic              soc_o,
  output logic [WORD_W-1:0] data_o
);
  int sent = 0;
  initial begin
    done_o = 1'b1;
    wr_n_o = 1'b1;
    soc_o  = 1'b0;
    data_o = 16'h0000;
  end
  // ==========================================================================
  // writes only while clav seen high, so a stale clav may overrun by one
  always @(posedge mclk_i) begin
    if (go_i) begin
      sent   <= 0;
      done_o <= 1'b0;
    end else if (!done_o && sent < words_i && clav_i) begin
      wr_n_o <= 1'b0;
      soc_o  <= (sent % 27 == 0);
      data_o <= 16'(sent);
      sent   <= sent + 1;
    end else begin
      wr_n_o <= 1'b1;
      soc_o  <= 1'b0;
      data_o <= ~data_o;              // released bus toggles between the last word and its inverse
      if (!done_o && sent >= words_i) done_o <= 1'b1;
    end
  end
endmodule

/* File: bench/tb.sv */
// self-checking bench for the transmit cell-available flow control
`timescale 1ns/1ps
module tb;
  import clav_pkg::*;
  logic              mclk_i = 0, reset_i = 1, fifo_ready_i = 1, fifo_read_i = 0, go = 0;
  logic [ADDR_W-1:0] tx_addr_i = 5'h00;
  mode_s             mode_i = '0;
  logic              wr_n, soc, done, clav, oe, clav_wire;
  logic [WORD_W-1:0] data;
  word_s             fifo_word;
  logic [FILL_W-1:0] fill;
  int                words = 0, mismatches = 0, num_checks = 0, pops = 0, p0;
  assign clav_wire = oe & clav;  // pulled low while released
  initial forever #12.5 mclk_i = ~mclk_i;
  word_s             first_word, last_word;
  always @(posedge mclk_i) if (fifo_word.valid === 1'b1) pops <= pops + 1;
  always @(posedge mclk_i) if (fifo_word.valid === 1'b1) last_word <= fifo_word;
  always @(posedge mclk_i) if (fifo_word.valid === 1'b1 && pops == p0) first_word <= fifo_word;
  tx_cell_available_flow_control uut (.mclk_i(mclk_i), .reset_i(reset_i), .mode_i(mode_i),
    .tx_addr_i(tx_addr_i), .tx_write_enable_n_i(wr_n), .tx_start_of_cell_in_i(soc),
    .tx_data_i(data), .fifo_ready_i(fifo_ready_i), .fifo_read_i(fifo_read_i),
    .tx_cell_available_out_o(clav), .tx_cell_available_oe_o(oe),
    .fifo_word_o(fifo_word), .fill_o(fill));
  atm_partner far (.mclk_i(mclk_i), .clav_i(clav_wire), .words_i(words), .go_i(go),
    .done_o(done), .wr_n_o(wr_n), .soc_o(soc), .data_o(data));
  // ==========================================================================
  // helpers
  task automatic check(input string what, input logic [FILL_W-1:0] seen, exp);
    num_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic stop_test();
    if (mismatches == 0 && num_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic restart(input mode_s m);
    @(posedge mclk_i);
    mode_i  <= m;
    reset_i <= 1'b1;
    repeat (20) @(posedge mclk_i);
    reset_i <= 1'b0;
  endtask
  task automatic send(input int n);
    @(posedge mclk_i);
    words <= n;
    go    <= 1'b1;
    @(posedge mclk_i);
    go <= 1'b0;
    @(posedge mclk_i);
    for (int i = 0; done !== 1'b1; i++) begin
      if (i > 2000) begin
        mismatches++;
        stop_test();
      end
      @(posedge mclk_i);
    end
    repeat (4) @(posedge mclk_i);
    #1;
  endtask
  // ==========================================================================
  // scenarios
  task automatic octet_mode();
    restart(mode_s'{1'b1, 1'b0, 1'b0, 1'b1, 5'h00});
    send(428);
    check("fill", fill, 10'h1ac);
    check("clav", clav_wire, 1'b1);
    send(1);
    check("clav", clav_wire, 1'b0);
    @(posedge mclk_i);
    fifo_read_i <= 1'b1;
    @(posedge mclk_i);
    fifo_read_i <= 1'b0;
    repeat (3) @(posedge mclk_i);
    #1;
    check("clav", clav_wire, 1'b1);
  endtask
  task automatic cell_mode();
    for (int b = 0; b < 2; b++) begin
      restart(mode_s'{1'b1, 1'b1, 1'b0, b[0], 5'h00});
      send(b ? 405 : 379);
      check("clav", clav_wire, 1'b1);
      send(1);
      check("clav", clav_wire, 1'b0);
    end
  endtask
  task automatic multi_phy();
    restart(mode_s'{1'b1, 1'b0, 1'b1, 1'b1, 5'h0a});
    tx_addr_i <= 5'h03;
    repeat (3) @(posedge mclk_i);
    #1;
    check("oe", oe, 1'b0);
    @(posedge mclk_i);
    tx_addr_i <= 5'h0a;
    @(posedge mclk_i);
    #1;
    check("oe", oe, 1'b0);
    repeat (2) @(posedge mclk_i);
    #1;
    check("oe", oe, 1'b1);
    send(406);
    check("clav", clav_wire, 1'b0);
    tx_addr_i <= 5'h03;
    repeat (3) @(posedge mclk_i);
    #1;
    check("oe", oe, 1'b0);
  endtask
  task automatic clear_and_stall();
    restart(mode_s'{1'b0, 1'b0, 1'b0, 1'b1, 5'h00});
    repeat (3) @(posedge mclk_i);
    #1;
    check("oe", oe, 1'b0);
    restart(mode_s'{1'b1, 1'b0, 1'b0, 1'b1, 5'h00});
    fifo_ready_i <= 1'b0;
    send(3);
    check("fill", fill, 10'h002);
    p0 = pops;
    fifo_ready_i <= 1'b1;
    repeat (6) @(posedge mclk_i);
    #1;
    check("pops", 10'(pops - p0), 10'h002);
    check("first soc", first_word.soc, 1'b1);
    check("first data", first_word.data[FILL_W-1:0], 10'h000);
    check("last soc", last_word.soc, 1'b0);
    check("last data", last_word.data[FILL_W-1:0], 10'h001);
  endtask
  initial begin
    octet_mode();
    cell_mode();
    multi_phy();
    clear_and_stall();
    stop_test();
  end
endmodule
